// file: core/sldr_pkg.sv
// constants, field layout and state type of the diagnostic record block
// assumes a single 50 MHz clock domain and an AXI4-Lite register bus
package sldr_pkg;

  // bus shape
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFFS_RECORD  = 12'h000;
  localparam logic [ADDR_W-1:0] OFFS_REQUEST = 12'h100;
  localparam logic [ADDR_W-1:0] OFFS_STATUS  = 12'h104;
  localparam logic [ADDR_W-1:0] OFFS_LIVE    = 12'h108;

  // status register fields
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_ERROR_BIT = 1;

  // record shape
  localparam logic [7:0] RECORD_NUMBER = 8'h5c;
  localparam int REC_BYTES   = 136;
  localparam int REC_WORDS   = 34;
  localparam int BANK_SLAVES = 31;
  localparam int ALL_SLAVES  = 62;

  // byte positions inside the record
  localparam int BYTE_MASTER  = 4;
  localparam int BYTE_A_FIRST = 8;
  localparam int BYTE_B_FIRST = 72;
  localparam int BYTE_FLAG1   = 134;
  localparam int BYTE_FLAG2   = 135;

  // master status byte fields
  localparam int MS_TEACH_ACTIVE = 0;
  localparam int MS_ONLINE       = 1;
  localparam int MS_PROTECTED    = 2;
  localparam int MS_TEACH_STATE  = 3;
  localparam int MS_TEACH_REQ    = 5;

  // per-slave diagnostic byte fields
  localparam int D1_IO_FAULT     = 0;
  localparam int D1_ACTIVE       = 1;
  localparam int D1_SAFETY       = 2;
  localparam int D1_CS_ERR_OP    = 3;
  localparam int D1_CS_ERR_TEACH = 4;
  localparam int D1_CS_NOT_UNIQ  = 5;
  localparam int D1_CS_NONE      = 6;
  localparam int D2_IN_ONE       = 0;
  localparam int D2_IN_TWO       = 1;
  localparam int D2_DISCREPANCY  = 2;
  localparam int D2_POWERUP_NOK  = 3;
  localparam int D2_TARGET_DIFF  = 4;

  // flag byte fields
  localparam int F1_OFFLINE_PHASE  = 0;
  localparam int F1_UNDERVOLTAGE   = 1;
  localparam int F1_NORMAL_MODE    = 2;
  localparam int F1_CONFIG_MODE    = 3;
  localparam int F1_READDRESS      = 4;
  localparam int F1_AUTO_ASSIGN    = 5;
  localparam int F1_ZERO_ADDRESS   = 6;
  localparam int F1_CONFIG_OK      = 7;
  localparam int F2_OFFLINE        = 0;
  localparam int F2_ALWAYS_ONE     = 1;
  localparam int F2_NVM_OK         = 2;
  localparam int F2_AUTO_ENABLE    = 3;
  localparam int F2_IO_FAULT       = 4;
  localparam int F2_POWER_ON       = 7;

  // reset values of the non-zero state bits
  localparam logic RESET_POWER_ON     = 1'b1;
  localparam logic RESET_OFFLINE_PREV = 1'b1;

  typedef logic [REC_BYTES-1:0][7:0] sldr_record_type;

  typedef struct packed {
    logic                 aw_held;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_held;
    logic [DATA_W-1:0]    wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [DATA_W-1:0]    rdata;
    logic [1:0]           rresp;
    sldr_record_type      rec;
    logic                 rec_valid;
    logic                 req_error;
    logic [7:0]           req_number;
    logic                 power_on_startup;
    logic                 offline_prev;
  } sldr_state_type;

endpackage

// file: core/sldr_slave_enc.sv
// encoder of the two diagnostic bytes of one slave address
// assumes per-slave status levels that are already synchronous
`timescale 1ns/1ps

module sldr_slave_enc (
  // first byte sources
  input  wire logic       io_fault_in,
  input  wire logic       active_in,
  input  wire logic       safety_in,
  input  wire logic       cs_err_op_in,
  input  wire logic       cs_err_teach_in,
  input  wire logic       cs_not_unique_in,
  input  wire logic       cs_none_in,
  // second byte sources
  input  wire logic       safety_input_one_in,
  input  wire logic       safety_input_two_in,
  input  wire logic       discrepancy_in,
  input  wire logic       powerup_not_met_in,
  input  wire logic       target_diff_in,
  // encoded bytes
  output logic [7:0]      diag1_out,
  output logic [7:0]      diag2_out
);

  always_comb begin
    diag1_out = 8'h00;
    diag2_out = 8'h00;
    diag1_out[sldr_pkg::D1_IO_FAULT]     = io_fault_in;
    diag1_out[sldr_pkg::D1_ACTIVE]       = active_in;
    diag1_out[sldr_pkg::D1_SAFETY]       = safety_in;
    diag1_out[sldr_pkg::D1_CS_ERR_OP]    = cs_err_op_in;
    diag1_out[sldr_pkg::D1_CS_ERR_TEACH] = cs_err_teach_in;
    diag1_out[sldr_pkg::D1_CS_NOT_UNIQ]  = cs_not_unique_in;
    diag1_out[sldr_pkg::D1_CS_NONE]      = cs_none_in;
    diag2_out[sldr_pkg::D2_IN_ONE]       = safety_input_one_in;
    diag2_out[sldr_pkg::D2_IN_TWO]       = safety_input_two_in;
    diag2_out[sldr_pkg::D2_DISCREPANCY]  = discrepancy_in;
    diag2_out[sldr_pkg::D2_POWERUP_NOK]  = powerup_not_met_in;
    diag2_out[sldr_pkg::D2_TARGET_DIFF]  = target_diff_in;
  end

endmodule

// file: core/sldr_top.sv
// diagnostic record assembly with an AXI4-Lite slave for software access
// assumes status inputs synchronous to REF_CLK_IN and a single master
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module sldr_top (
  // clock and reset
  input  wire logic                        REF_CLK_IN,
  input  wire logic                        RESET_N_IN,
  // AXI4-Lite write address and data
  input  wire logic                        S_AXI_AWVALID_IN,
  output logic                             S_AXI_AWREADY_OUT,
  input  wire logic [sldr_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic [2:0]                  S_AXI_AWPROT_IN,
  input  wire logic                        S_AXI_WVALID_IN,
  output logic                             S_AXI_WREADY_OUT,
  input  wire logic [sldr_pkg::DATA_W-1:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]                  S_AXI_WSTRB_IN,
  // AXI4-Lite write response
  output logic                             S_AXI_BVALID_OUT,
  input  wire logic                        S_AXI_BREADY_IN,
  output logic [1:0]                       S_AXI_BRESP_OUT,
  // AXI4-Lite read
  input  wire logic                        S_AXI_ARVALID_IN,
  output logic                             S_AXI_ARREADY_OUT,
  input  wire logic [sldr_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic [2:0]                  S_AXI_ARPROT_IN,
  output logic                             S_AXI_RVALID_OUT,
  input  wire logic                        S_AXI_RREADY_IN,
  output logic [sldr_pkg::DATA_W-1:0]      S_AXI_RDATA_OUT,
  output logic [1:0]                       S_AXI_RRESP_OUT,
  // master status
  input  wire logic                        TEACH_ACTIVE_IN,
  input  wire logic                        MASTER_ONLINE_IN,
  input  wire logic                        PROTECTED_MODE_IN,
  input  wire logic [1:0]                  TEACH_STATE_IN,
  input  wire logic                        TEACH_REQUIRED_IN,
  // per-slave status, bit k: k<31 slave k+1 (single/A), else slave k-30 (B)
  input  wire logic [61:0]                 SLAVE_IO_FAULT_IN,
  input  wire logic [61:0]                 SLAVE_ACTIVE_IN,
  input  wire logic [61:0]                 SLAVE_SAFETY_IN,
  input  wire logic [61:0]                 SLAVE_CS_ERR_OP_IN,
  input  wire logic [61:0]                 SLAVE_CS_ERR_TEACH_IN,
  input  wire logic [61:0]                 SLAVE_CS_NOT_UNIQUE_IN,
  input  wire logic [61:0]                 SLAVE_CS_NONE_IN,
  input  wire logic [61:0]                 SAFETY_INPUT_ONE_IN,
  input  wire logic [61:0]                 SAFETY_INPUT_TWO_IN,
  input  wire logic [61:0]                 SLAVE_DISCREPANCY_IN,
  input  wire logic [61:0]                 SLAVE_POWERUP_NOK_IN,
  input  wire logic [61:0]                 SLAVE_TARGET_DIFF_IN,
  // configuration lists, same bit order as the slave buses
  input  wire logic [61:0]                 CONFIGURED_LIST_IN,
  input  wire logic [61:0]                 DETECTED_LIST_IN,
  // line and gateway status
  input  wire logic                        OFFLINE_PHASE_IN,
  input  wire logic                        LINE_UNDERVOLTAGE_IN,
  input  wire logic                        NORMAL_MODE_IN,
  input  wire logic                        CONFIG_MODE_IN,
  input  wire logic                        AUTO_ADDR_ENABLE_IN,
  input  wire logic                        WRONG_SLAVE_PRESENT_IN,
  input  wire logic                        ZERO_ADDRESS_PRESENT_IN,
  input  wire logic                        NVM_TEST_OK_IN,
  input  wire logic                        OFFLINE_REQUEST_IN,
  input  wire logic                        OFFLINE_STATE_IN
);

  sldr_pkg::sldr_state_type  s;
  sldr_pkg::sldr_state_type  next_s;
  sldr_pkg::sldr_record_type live;
  logic [61:0][7:0]          diag1;
  logic [61:0][7:0]          diag2;
  logic [61:0]               missing;
  logic                      commit;
  logic                      commit_req;
  logic                      rd_take;

  // exactly one bit set; false for an empty list
  function automatic logic one_hot(input logic [61:0] v);
    logic [6:0] cnt;
    cnt = 7'h00;
    for (int i = 0; i < 62; i++) begin
      cnt = cnt + 7'(v[i]);
    end
    return cnt == 7'h01;
  endfunction

  // little-endian word of the captured record
  function automatic logic [31:0] record_word(input sldr_pkg::sldr_record_type r,
                                              input logic [5:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      w[8*b +: 8] = r[4*int'(idx) + b];
    end
    return w;
  endfunction

  genvar g;
  generate
    for (g = 0; g < sldr_pkg::ALL_SLAVES; g++) begin : g_slave
      sldr_slave_enc u_enc (
        .io_fault_in         (SLAVE_IO_FAULT_IN[g]),
        .active_in           (SLAVE_ACTIVE_IN[g]),
        .safety_in           (SLAVE_SAFETY_IN[g]),
        .cs_err_op_in        (SLAVE_CS_ERR_OP_IN[g]),
        .cs_err_teach_in     (SLAVE_CS_ERR_TEACH_IN[g]),
        .cs_not_unique_in    (SLAVE_CS_NOT_UNIQUE_IN[g]),
        .cs_none_in          (SLAVE_CS_NONE_IN[g]),
        .safety_input_one_in (SAFETY_INPUT_ONE_IN[g]),
        .safety_input_two_in (SAFETY_INPUT_TWO_IN[g]),
        .discrepancy_in      (SLAVE_DISCREPANCY_IN[g]),
        .powerup_not_met_in  (SLAVE_POWERUP_NOK_IN[g]),
        .target_diff_in      (SLAVE_TARGET_DIFF_IN[g]),
        .diag1_out           (diag1[g]),
        .diag2_out           (diag2[g])
      );
    end
  endgenerate

  assign missing = CONFIGURED_LIST_IN & ~DETECTED_LIST_IN;

  // live image of the record; everything not written stays zero
  always_comb begin
    live = '0;
    live[sldr_pkg::BYTE_MASTER][sldr_pkg::MS_TEACH_ACTIVE] = TEACH_ACTIVE_IN;
    live[sldr_pkg::BYTE_MASTER][sldr_pkg::MS_ONLINE]       = MASTER_ONLINE_IN;
    live[sldr_pkg::BYTE_MASTER][sldr_pkg::MS_PROTECTED]    = PROTECTED_MODE_IN;
    live[sldr_pkg::BYTE_MASTER][sldr_pkg::MS_TEACH_REQ]    = TEACH_REQUIRED_IN;
    live[sldr_pkg::BYTE_MASTER][sldr_pkg::MS_TEACH_STATE +: 2] = TEACH_STATE_IN;
    for (int k = 0; k < sldr_pkg::BANK_SLAVES; k++) begin
      live[sldr_pkg::BYTE_A_FIRST + 2*k]     = diag1[k];
      live[sldr_pkg::BYTE_A_FIRST + 2*k + 1] = diag2[k];
      live[sldr_pkg::BYTE_B_FIRST + 2*k]     = diag1[k + 31];
      live[sldr_pkg::BYTE_B_FIRST + 2*k + 1] = diag2[k + 31];
    end
    live[sldr_pkg::BYTE_FLAG1][sldr_pkg::F1_OFFLINE_PHASE] = OFFLINE_PHASE_IN;
    live[sldr_pkg::BYTE_FLAG1][sldr_pkg::F1_UNDERVOLTAGE]  = LINE_UNDERVOLTAGE_IN;
    live[sldr_pkg::BYTE_FLAG1][sldr_pkg::F1_NORMAL_MODE]   = NORMAL_MODE_IN;
    live[sldr_pkg::BYTE_FLAG1][sldr_pkg::F1_CONFIG_MODE]   = CONFIG_MODE_IN;
    live[sldr_pkg::BYTE_FLAG1][sldr_pkg::F1_READDRESS]     = one_hot(missing);
    live[sldr_pkg::BYTE_FLAG1][sldr_pkg::F1_AUTO_ASSIGN]   =
      AUTO_ADDR_ENABLE_IN & ~WRONG_SLAVE_PRESENT_IN;
    live[sldr_pkg::BYTE_FLAG1][sldr_pkg::F1_ZERO_ADDRESS]  = ZERO_ADDRESS_PRESENT_IN;
    live[sldr_pkg::BYTE_FLAG1][sldr_pkg::F1_CONFIG_OK]     =
      (CONFIGURED_LIST_IN == DETECTED_LIST_IN);
    live[sldr_pkg::BYTE_FLAG2][sldr_pkg::F2_OFFLINE]       =
      OFFLINE_REQUEST_IN | OFFLINE_STATE_IN;
    live[sldr_pkg::BYTE_FLAG2][sldr_pkg::F2_ALWAYS_ONE]    = 1'b1;
    live[sldr_pkg::BYTE_FLAG2][sldr_pkg::F2_NVM_OK]        = NVM_TEST_OK_IN;
    live[sldr_pkg::BYTE_FLAG2][sldr_pkg::F2_AUTO_ENABLE]   = AUTO_ADDR_ENABLE_IN;
    live[sldr_pkg::BYTE_FLAG2][sldr_pkg::F2_IO_FAULT]      = |SLAVE_IO_FAULT_IN;
    live[sldr_pkg::BYTE_FLAG2][sldr_pkg::F2_POWER_ON]      = s.power_on_startup;
  end

  // handshake outputs straight from state
  assign S_AXI_AWREADY_OUT = ~s.aw_held;
  assign S_AXI_WREADY_OUT  = ~s.w_held;
  assign S_AXI_ARREADY_OUT = ~s.rvalid;
  assign S_AXI_BVALID_OUT  = s.bvalid;
  assign S_AXI_BRESP_OUT   = s.bresp;
  assign S_AXI_RVALID_OUT  = s.rvalid;
  assign S_AXI_RDATA_OUT   = s.rdata;
  assign S_AXI_RRESP_OUT   = s.rresp;

  assign commit     = s.aw_held & s.w_held & ~s.bvalid;
  assign commit_req = commit & (s.aw_addr[11:2] == sldr_pkg::OFFS_REQUEST[11:2]) & s.wstrb[0];
  assign rd_take    = S_AXI_ARVALID_IN & ~s.rvalid;

  always_comb begin
    next_s = s;
    if (S_AXI_AWVALID_IN && !s.aw_held) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && !s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = S_AXI_WDATA_IN;
      next_s.wstrb  = S_AXI_WSTRB_IN;
    end
    if (s.bvalid && S_AXI_BREADY_IN) begin
      next_s.bvalid = 1'b0;
    end
    // both halves held: perform the write, then answer
    if (commit) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = sldr_pkg::RESP_SLVERR;
      if (s.aw_addr[11:2] == sldr_pkg::OFFS_REQUEST[11:2]) begin
        next_s.bresp = sldr_pkg::RESP_OKAY;
      end
      if (commit_req) begin
        next_s.req_number = s.wdata[7:0];
        if (s.wdata[7:0] == sldr_pkg::RECORD_NUMBER) begin
          // whole image in one edge, so a read never mixes two samples
          next_s.rec       = live;
          next_s.rec_valid = 1'b1;
          next_s.req_error = 1'b0;
        end else begin
          // only one record exists; an old capture is kept but marked stale
          next_s.rec_valid = 1'b0;
          next_s.req_error = 1'b1;
        end
      end
    end
    if (s.rvalid && S_AXI_RREADY_IN) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = sldr_pkg::RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      if (S_AXI_ARADDR_IN[11:8] == sldr_pkg::OFFS_RECORD[11:8] &&
          int'(S_AXI_ARADDR_IN[7:2]) < sldr_pkg::REC_WORDS) begin
        next_s.rdata = record_word(s.rec, S_AXI_ARADDR_IN[7:2]);
      end else if (S_AXI_ARADDR_IN[11:2] == sldr_pkg::OFFS_REQUEST[11:2]) begin
        next_s.rdata[7:0] = s.req_number;
      end else if (S_AXI_ARADDR_IN[11:2] == sldr_pkg::OFFS_STATUS[11:2]) begin
        next_s.rdata[sldr_pkg::STAT_VALID_BIT] = s.rec_valid;
        next_s.rdata[sldr_pkg::STAT_ERROR_BIT] = s.req_error;
      end else if (S_AXI_ARADDR_IN[11:2] == sldr_pkg::OFFS_LIVE[11:2]) begin
        next_s.rdata[23:0] = {live[sldr_pkg::BYTE_MASTER],
                              live[sldr_pkg::BYTE_FLAG2],
                              live[sldr_pkg::BYTE_FLAG1]};
      end else begin
        next_s.rresp = sldr_pkg::RESP_SLVERR;
      end
    end
    // a master already offline at release needs a fresh move to clear
    if (OFFLINE_STATE_IN && !s.offline_prev) begin
      next_s.power_on_startup = 1'b0;
    end
    next_s.offline_prev = OFFLINE_STATE_IN;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      s                  <= '0;
      s.power_on_startup <= sldr_pkg::RESET_POWER_ON;
      s.offline_prev     <= sldr_pkg::RESET_OFFLINE_PREV;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  a_good_request: assert property (commit_req && s.wdata[7:0] == 8'h5c
    |=> s.rec_valid && !s.req_error && s.rec == $past(live))
    else $error("record 92 request did not capture the record");

  a_bad_request: assert property (commit_req && s.wdata[7:0] != 8'h5c
    |=> !s.rec_valid && s.req_error)
    else $error("wrong record number was not refused");

  a_capture_steady: assert property (!commit_req |=> $stable(s.rec))
    else $error("captured record changed without a request");

  a_reserved_zero: assert property (s.rec[70] == 8'h00 && s.rec[71] == 8'h00 &&
    s.rec[0] == 8'h00 && s.rec[4][7:6] == 2'b00)
    else $error("reserved record content is not zero");

  a_slave_one_map: assert property (live[8][1] == SLAVE_ACTIVE_IN[0] &&
    live[9][0] == SAFETY_INPUT_ONE_IN[0])
    else $error("slave 1 bytes misplaced");

  a_b_slave_map: assert property (live[133][4] == SLAVE_TARGET_DIFF_IN[61] &&
    live[72][6] == SLAVE_CS_NONE_IN[31])
    else $error("B slave bytes misplaced");

  a_teach_state: assert property (live[4][4:3] == TEACH_STATE_IN)
    else $error("teach state field wrong");

  a_readdress: assert property ((CONFIGURED_LIST_IN == DETECTED_LIST_IN)
    |-> !live[134][4] && live[134][7])
    else $error("readdress flag set with nothing missing");

  a_always_one: assert property (live[135][1] && live[135][3] == AUTO_ADDR_ENABLE_IN)
    else $error("flag 2 fixed bit or enable bit wrong");

  // a rise seen across the release edge is not a move to offline
  a_power_on_clear: assert property ($rose(OFFLINE_STATE_IN) && $past(RESET_N_IN)
    |=> !live[135][7] [*2])
    else $error("power-on flag not cleared on going offline");

  a_power_on_hold: assert property (!s.power_on_startup |=> !s.power_on_startup)
    else $error("power-on flag set again without reset");

  a_flag1_levels: assert property (
    live[134][3:0] == {CONFIG_MODE_IN, NORMAL_MODE_IN, LINE_UNDERVOLTAGE_IN, OFFLINE_PHASE_IN})
    else $error("flag 1 level bits misplaced");

  a_auto_assign: assert property (WRONG_SLAVE_PRESENT_IN |-> !live[134][5])
    else $error("auto assign flag set with a wrong slave present");

  a_zero_address: assert property (live[134][6] == ZERO_ADDRESS_PRESENT_IN)
    else $error("zero address flag wrong");

  a_offline_flag: assert property ((OFFLINE_REQUEST_IN || OFFLINE_STATE_IN) |-> live[135][0])
    else $error("offline flag not set");

  a_io_fault_any: assert property (live[135][4] == (|SLAVE_IO_FAULT_IN))
    else $error("io fault summary flag wrong");

  a_read_answer: assert property (rd_take |=> s.rvalid)
    else $error("read not answered in one cycle");

  a_read_hold: assert property (s.rvalid && !S_AXI_RREADY_IN |=> s.rvalid && $stable(s.rdata))
    else $error("read answer changed before it was taken");

  a_write_answer: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT &&
    S_AXI_WVALID_IN && S_AXI_WREADY_OUT |-> ##[1:2] s.bvalid)
    else $error("write not answered");

  c_good_request: cover property (commit_req && s.wdata[7:0] == 8'h5c);
  c_bad_request: cover property (commit_req && s.wdata[7:0] != 8'h5c);
  c_record_read: cover property (rd_take && S_AXI_ARADDR_IN[11:8] == 4'h0);
  c_power_on_clear: cover property ($fell(s.power_on_startup));

endmodule

// file: verif/sldr_ctrl_model.sv
// controller model: AXI4-Lite master that requests and reads records
// assumes the block's clock; the bench calls its tasks
`timescale 1ns/1ps
module sldr_ctrl_model (
  // clock
  input  wire logic        clk_in,
  // write side
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [11:0]      awaddr_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  output logic [31:0]      wdata_out,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  input  wire logic [1:0]  bresp_in,
  // read side
  output logic             arvalid_out,
  input  wire logic        arready_in,
  output logic [11:0]      araddr_out,
  input  wire logic        rvalid_in,
  output logic             rready_out,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in
);
  initial {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
  initial {awaddr_out, araddr_out, wdata_out} = 56'h0;
  // record request is a write of its number
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, got;
    {ta, tw, got} = 3'h0;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    {awvalid_out, wvalid_out, bready_out} <= 3'h7;
    while (!got) begin
      @(negedge clk_in);
      ta = ta | awready_in;
      tw = tw | wready_in;
      got = bvalid_in;
      r = bresp_in;
      @(posedge clk_in);
      if (ta) awvalid_out <= 1'b0;
      if (tw) wvalid_out <= 1'b0;
    end
    bready_out <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, got;
    {ta, got} = 2'h0;
    @(posedge clk_in);
    araddr_out <= a;
    {arvalid_out, rready_out} <= 2'h3;
    while (!got) begin
      @(negedge clk_in);
      ta = ta | arready_in;
      got = rvalid_in;
      d = rdata_in;
      r = rresp_in;
      @(posedge clk_in);
      if (ta) arvalid_out <= 1'b0;
    end
    rready_out <= 1'b0;
  endtask
endmodule

// file: verif/safety_link_diag_record_bench.sv
// bench: random status, record requests, whole-record reads vs model
// assumes one 50 MHz clock shared with the controller model
`timescale 1ns/1ps
module safety_link_diag_record_bench;
  logic clk = 1'b0, rst_n = 1'b0, po, pv, cpo;
  logic [61:0] sv [14];
  logic [61:0] cs [14];
  logic [15:0] g, cg;
  logic awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdt, d;
  logic [1:0] bre, rre, r;
  logic [31:0] exp_q [$];
  int seed = 93804, failures = 0, total_checks = 0, i;
  sldr_top sldr_top_inst (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa), .S_AXI_AWPROT_IN(3'h0),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(brd), .S_AXI_BRESP_OUT(bre),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
    .S_AXI_ARPROT_IN(3'h0), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rrd),
    .S_AXI_RDATA_OUT(rdt), .S_AXI_RRESP_OUT(rre), .TEACH_ACTIVE_IN(g[0]),
    .MASTER_ONLINE_IN(g[1]), .PROTECTED_MODE_IN(g[2]), .TEACH_STATE_IN(g[15:14]),
    .TEACH_REQUIRED_IN(g[3]), .SLAVE_IO_FAULT_IN(sv[0]), .SLAVE_ACTIVE_IN(sv[1]),
    .SLAVE_SAFETY_IN(sv[2]), .SLAVE_CS_ERR_OP_IN(sv[3]), .SLAVE_CS_ERR_TEACH_IN(sv[4]),
    .SLAVE_CS_NOT_UNIQUE_IN(sv[5]), .SLAVE_CS_NONE_IN(sv[6]), .SAFETY_INPUT_ONE_IN(sv[7]),
    .SAFETY_INPUT_TWO_IN(sv[8]), .SLAVE_DISCREPANCY_IN(sv[9]), .SLAVE_POWERUP_NOK_IN(sv[10]),
    .SLAVE_TARGET_DIFF_IN(sv[11]), .CONFIGURED_LIST_IN(sv[12]), .DETECTED_LIST_IN(sv[13]),
    .OFFLINE_PHASE_IN(g[4]), .LINE_UNDERVOLTAGE_IN(g[5]), .NORMAL_MODE_IN(g[6]),
    .CONFIG_MODE_IN(g[7]), .AUTO_ADDR_ENABLE_IN(g[8]), .WRONG_SLAVE_PRESENT_IN(g[9]),
    .ZERO_ADDRESS_PRESENT_IN(g[10]), .NVM_TEST_OK_IN(g[11]), .OFFLINE_REQUEST_IN(g[12]),
    .OFFLINE_STATE_IN(g[13]));
  sldr_ctrl_model sldr_ctrl_model_inst (.clk_in(clk), .awvalid_out(awv), .awready_in(awr),
    .awaddr_out(awa), .wvalid_out(wv), .wready_in(wrd), .wdata_out(wd), .bvalid_in(bv),
    .bready_out(brd), .bresp_in(bre), .arvalid_out(arv), .arready_in(arr), .araddr_out(ara),
    .rvalid_in(rv), .rready_out(rrd), .rdata_in(rdt), .rresp_in(rre));
  initial forever #10 clk = ~clk;
  // power-on flag reference: cleared only by a new rise of offline state
  always @(posedge clk) begin
    pv <= rst_n ? g[13] : 1'b1;
    po <= !rst_n | (po & !(g[13] & !pv));
  end
  function automatic logic [7:0] eb(int i);
    int k;
    k = (i < 70) ? (i - 8) / 2 : (i - 72) / 2 + 31;
    eb = 8'h00;
    if (i == 4) eb = {2'h0, cg[3], cg[15:14], cg[2], cg[1], cg[0]};
    if (i >= 8 && i < 134 && i != 70 && i != 71)
      for (int j = 0; j < 7; j++) if (i % 2 == 0 || j < 5) eb[j] = cs[j + 7 * (i % 2)][k];
    if (i == 134) eb = {cs[12] == cs[13], cg[10], cg[8] & ~cg[9],
      $countones(cs[12] & ~cs[13]) == 1, cg[7:4]};
    if (i == 135) eb = {cpo, 2'h0, |cs[0], cg[8], cg[11], 1'b1, cg[12] | cg[13]};
  endfunction
  task automatic rnd(input int t);
    logic [61:0] c;
    c = 62'({$random(seed), $random(seed)});
    @(posedge clk);
    for (int j = 0; j < 12; j++) sv[j] <= 62'({$random(seed), $random(seed)});
    sv[12] <= c;
    // no difference, one differing bit or two differing bits
    sv[13] <= c ^ (62'(t % 3 == 2 ? 3 : t % 3) << t);
    g <= {t[1:0], 14'($random(seed))};
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 14; i++) sv[i] = 62'h0;
    g = 16'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int t = 0; t < 8; t++) begin
      rnd(t);
      repeat (2) @(posedge clk);
      sldr_ctrl_model_inst.wr(12'h100, 32'h5c, r);
      check(32'(r), 32'h0);
      cs = sv;
      cg = g;
      cpo = po;
      // expected words frozen at the capture, read back later in order
      for (i = 0; i < 34; i++) exp_q.push_back({eb(4*i+3), eb(4*i+2), eb(4*i+1), eb(4*i)});
      if (t[0]) sldr_ctrl_model_inst.wr(12'h100, 32'h5b, r);
      sldr_ctrl_model_inst.rd(12'h104, d, r);
      check(d, t[0] ? 32'h2 : 32'h1);
      sldr_ctrl_model_inst.rd(12'h100, d, r);
      check(d, t[0] ? 32'h5b : 32'h5c);
      rnd(t + 3);
      for (i = 0; i < 34; i++) begin
        sldr_ctrl_model_inst.rd(12'(4 * i), d, r);
        check(d, exp_q.pop_front());
        check(32'(r), 32'h0);
      end
      cs = sv;
      cg = g;
      cpo = po;
      sldr_ctrl_model_inst.rd(12'h108, d, r);
      check(d, {8'h00, eb(4), eb(135), eb(134)});
      $display("round %0d done", t);
    end
    sldr_ctrl_model_inst.rd(12'h200, d, r);
    check({d[29:0], r}, 32'h2);
    sldr_ctrl_model_inst.wr(12'h104, 32'h1, r);
    check(32'(r), 32'h2);
    $display("refusal test done");
    complete_run();
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule
